// ### core/eaf_filter.sv
// eaf_filter: receive address filter, tag check, buffer split and packet memory
//
// Functional notes
// - first received destination bit zero means single-node, one means group.
// - all-ones group destination is broadcast, accepted unless broadcast_reject set; accept_everything without inverse still passes it.
// - perfect mode passes single-node frames equal to the station address.
// - inverse mode passes single-node frames differing from the station address.
// - exact and inverse compares apply only to single-node frames.
// - five mode bits select unicast and group criteria per the mode table.
// - accept_everything without inverse passes everything; this is the reset state.
// - some modes pass or fail whole frame classes without any compare.
// - hash runs all six destination bytes through the CRC-32 engine.
// - top six CRC bits index; top bit picks high/low table word.
// - hashed address passes only when its indexed table bit is one.
// - each frame reports pass/fail, broadcast and multicast in its status.
// - frame bytes 13 and 14 compared with both tag registers.
// - non-zero single tag match marks frame and adds 4 bytes to limit.
// - non-zero double tag match marks frame and adds 20 bytes to limit.
// - packet memory is 32 pages of 64 four-byte words.
// - low five split bits give receive pages from page 0; rest transmit.
// - split resets to zero, all transmit; maximum leaves page 31 transmit.
// - any change of the split flushes receive buffer and receive FIFO.
// - window select places memory at 00e000, 000000, ffe000; 11 reserved.
// - buffer control unit and cpu both read and write the packet memory.
// - status filter_fail_flag is one on failed filter, zero on pass.
`timescale 1ns/1ns
module eaf_filter
  import eaf_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  nrst,
  input  wire logic                  ce,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [31:0]           reg_rdata,
  input  wire logic                  rx_valid,
  input  wire logic                  rx_sof,
  input  wire logic                  rx_eof,
  input  wire logic [7:0]            rx_byte,
  output eaf_rx_status_t             rx_status,
  output logic                       rx_status_valid,
  output logic                       rx_flush,
  output logic      [4:0]            rx_page_count,
  input  wire logic                  bctl_req,
  input  wire logic                  bctl_we,
  input  wire logic [WA_W-1:0]       bctl_addr,
  input  wire logic [31:0]           bctl_wdata,
  output logic      [31:0]           bctl_rdata,
  output logic                       bctl_ack,
  input  wire logic                  cpu_req,
  input  wire eaf_cpu_req_t          cpu,
  output logic      [7:0]            cpu_rdata,
  output logic                       cpu_ack
);

  // software registers
  logic [31:0] mac_control, station_address_high, station_address_low;
  logic [31:0] hash_table_high, hash_table_low, single_tag_match, double_tag_match;
  logic [31:0] last_status;
  logic [1:0]  buffer_window_select;
  logic [4:0]  buffer_split_size;
  logic [31:0] next_mac_control, next_sta_high, next_sta_low;
  logic [31:0] next_hash_high, next_hash_low, next_single_tag, next_double_tag;
  logic [31:0] next_last_status, next_reg_rdata;
  logic [1:0]  next_window;
  logic [4:0]  next_split;
  logic        next_flush;

  // receive state
  logic [13:0]    count, idx, next_count, frame_len, max_len;
  logic [47:0]    da, next_da, station;
  logic [31:0]    crc, next_crc;
  logic [15:0]    tag, next_tag;
  eaf_rx_status_t next_status;
  logic           next_status_valid;

  // decision terms
  logic       group, bcast, da_match, hash_hit, single_hit, double_hit, fail;
  logic [5:0] hash_idx;
  logic [4:0] mode;

  // memory and arbitration
  logic [31:0]     mem [SRAM_WORDS];
  logic [23:0]     win_base;
  logic            cpu_hit, cpu_go, next_cpu_ack, next_bctl_ack;
  logic [WA_W-1:0] cpu_word;

  // one byte of CRC-32, least significant bit first as received
  function automatic logic [31:0] crc_byte(input logic [31:0] c_in, input logic [7:0] d);
    logic [31:0] c;
    logic        fb;
    c = c_in;
    for (int i = 0; i < 8; i++) begin
      fb = c[31] ^ d[i];
      c  = {c[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h0000_0000);
    end
    return c;
  endfunction

  // register writes, read mux and split-change detect
  always_comb begin
    next_mac_control = mac_control;
    next_sta_high    = station_address_high;
    next_sta_low     = station_address_low;
    next_hash_high   = hash_table_high;
    next_hash_low    = hash_table_low;
    next_single_tag  = single_tag_match;
    next_double_tag  = double_tag_match;
    next_window      = buffer_window_select;
    next_split       = buffer_split_size;
    next_flush       = 1'b0;
    next_reg_rdata   = 32'h0000_0000;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_MAC_CONTROL: next_mac_control = reg_wdata;
        ADDR_STA_HIGH:    next_sta_high    = reg_wdata;
        ADDR_STA_LOW:     next_sta_low     = reg_wdata;
        ADDR_HASH_HIGH:   next_hash_high   = reg_wdata;
        ADDR_HASH_LOW:    next_hash_low    = reg_wdata;
        ADDR_SINGLE_TAG:  next_single_tag  = reg_wdata;
        ADDR_DOUBLE_TAG:  next_double_tag  = reg_wdata;
        ADDR_MEM_WINDOW:  next_window      = reg_wdata[WIN_LO+1:WIN_LO];
        ADDR_SPLIT_SIZE: begin
          next_split = reg_wdata[4:0];
          next_flush = reg_wdata[4:0] != buffer_split_size;
        end
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        ADDR_MAC_CONTROL: next_reg_rdata = mac_control;
        ADDR_STA_HIGH:    next_reg_rdata = station_address_high;
        ADDR_STA_LOW:     next_reg_rdata = station_address_low;
        ADDR_HASH_HIGH:   next_reg_rdata = hash_table_high;
        ADDR_HASH_LOW:    next_reg_rdata = hash_table_low;
        ADDR_SINGLE_TAG:  next_reg_rdata = single_tag_match;
        ADDR_DOUBLE_TAG:  next_reg_rdata = double_tag_match;
        ADDR_LAST_STATUS: next_reg_rdata = last_status;
        ADDR_MEM_WINDOW:  next_reg_rdata = {24'h0, buffer_window_select, 6'h00};
        ADDR_SPLIT_SIZE:  next_reg_rdata = {27'h0, buffer_split_size};
        default:          next_reg_rdata = 32'h0000_0000;
      endcase
    end
  end

  // register file flops; reset passes everything and gives all pages to transmit
  always_ff @(posedge clock) begin
    if (!nrst) begin
      mac_control          <= MAC_CONTROL_RST;
      station_address_high <= 32'h0000_0000;
      station_address_low  <= 32'h0000_0000;
      hash_table_high      <= 32'h0000_0000;
      hash_table_low       <= 32'h0000_0000;
      single_tag_match     <= 32'h0000_0000;
      double_tag_match     <= 32'h0000_0000;
      buffer_window_select <= WIN_RST;
      buffer_split_size    <= SPLIT_RST;
      rx_flush             <= 1'b0;
      reg_rdata            <= 32'h0000_0000;
      rx_page_count        <= SPLIT_RST;
    end else if (ce) begin
      mac_control          <= next_mac_control;
      station_address_high <= next_sta_high;
      station_address_low  <= next_sta_low;
      hash_table_high      <= next_hash_high;
      hash_table_low       <= next_hash_low;
      single_tag_match     <= next_single_tag;
      double_tag_match     <= next_double_tag;
      buffer_window_select <= next_window;
      buffer_split_size    <= next_split;
      rx_flush             <= next_flush;
      reg_rdata            <= next_reg_rdata;
      rx_page_count        <= next_split;
    end
  end

  // address class, exact compare, hash lookup and tag compare
  always_comb begin
    station    = {station_address_high[15:0], station_address_low};
    group      = da[40];
    bcast      = group && (&da);
    da_match   = da == station;
    hash_idx   = crc[31:26];
    hash_hit   = hash_idx[5] ? hash_table_high[hash_idx[4:0]]
                             : hash_table_low[hash_idx[4:0]];
    single_hit = (|single_tag_match[15:0]) && tag == single_tag_match[15:0];
    double_hit = (|double_tag_match[15:0]) && tag == double_tag_match[15:0];
    mode       = {mac_control[MC_PASS_GROUP], mac_control[MC_ACCEPT_ALL],
                  mac_control[MC_INVERSE], mac_control[MC_HASH_SINGLE],
                  mac_control[MC_HASH_GROUP]};
    // pass/fail per mode bits
    if (mode[3] && !mode[2]) begin
      fail = 1'b0;
    end else if (bcast) begin
      fail = mac_control[MC_BCAST_REJECT];
    end else if (group) begin
      if (mode[4]) begin
        fail = 1'b0;
      end else if (mode[0]) begin
        fail = !hash_hit;
      end else begin
        fail = 1'b1;
      end
    end else if (mode[1]) begin
      fail = !hash_hit;
    end else if (mode[2]) begin
      fail = da_match;
    end else begin
      fail = !da_match;
    end
    // legal length grows with the tag kind
    if (double_hit) begin
      max_len = BASE_MAX_LEN + DOUBLE_EXTRA;
    end else if (single_hit) begin
      max_len = BASE_MAX_LEN + SINGLE_EXTRA;
    end else begin
      max_len = BASE_MAX_LEN;
    end
  end

  // byte stream walk: destination capture, hash CRC, tag bytes, end-of-frame status
  always_comb begin
    idx               = rx_sof ? 14'h0000 : count;
    frame_len         = idx + 14'h0001;
    next_count        = count;
    next_da           = da;
    next_crc          = crc;
    next_tag          = tag;
    next_status       = rx_status;
    next_status_valid = 1'b0;
    next_last_status  = last_status;
    if (rx_valid) begin
      next_count = frame_len;
      if (idx < DA_BYTES) begin
        next_da  = {da[39:0], rx_byte};
        next_crc = crc_byte(rx_sof ? CRC_PRESET : crc, rx_byte);
      end
      if (idx == TAG_HI_IDX) begin
        next_tag[15:8] = rx_byte;
      end
      if (idx == TAG_LO_IDX) begin
        next_tag[7:0] = rx_byte;
      end
      if (rx_eof) begin
        next_status_valid       = 1'b1;
        next_status.filter_fail = fail;
        next_status.broadcast   = bcast;
        next_status.multicast   = group;
        next_status.double_tag  = double_hit;
        next_status.single_tag  = single_hit;
        next_status.too_long    = frame_len > max_len;
        next_status.length      = frame_len;
        next_last_status        = {18'h0, frame_len};
        next_last_status[ST_FAIL] = fail;
        next_last_status[ST_BC] = bcast;
        next_last_status[ST_MC] = group;
        next_last_status[ST_V2] = double_hit;
        next_last_status[ST_V1] = single_hit;
        next_last_status[ST_LG] = frame_len > max_len;
      end
    end
  end

  // receive flops
  always_ff @(posedge clock) begin
    if (!nrst) begin
      count           <= 14'h0000;
      da              <= 48'h0;
      crc             <= CRC_PRESET;
      tag             <= 16'h0000;
      rx_status       <= '0;
      rx_status_valid <= 1'b0;
      last_status     <= 32'h0000_0000;
    end else if (ce) begin
      count           <= next_count;
      da              <= next_da;
      crc             <= next_crc;
      tag             <= next_tag;
      rx_status       <= next_status;
      rx_status_valid <= next_status_valid;
      last_status     <= next_last_status;
    end
  end

  // cpu window decode and arbitration, buffer control unit first
  always_comb begin
    case (buffer_window_select)
      2'h0:    win_base = WIN_BASE_0;
      2'h1:    win_base = WIN_BASE_1;
      2'h2:    win_base = WIN_BASE_2;
      default: win_base = WIN_BASE_0;
    endcase
    cpu_hit      = buffer_window_select != 2'h3 && cpu.addr[23:13] == win_base[23:13];
    cpu_word     = cpu.addr[12:2];
    next_bctl_ack = bctl_req;
    cpu_go       = cpu_req && cpu_hit && !cpu_ack && !bctl_req;
    next_cpu_ack = cpu_go;
  end

  // packet memory: one access per cycle, losing cpu waits for a free cycle
  always_ff @(posedge clock) begin
    if (!nrst) begin
      bctl_ack   <= 1'b0;
      cpu_ack    <= 1'b0;
      bctl_rdata <= 32'h0000_0000;
      cpu_rdata  <= 8'h00;
    end else if (ce) begin
      bctl_ack <= next_bctl_ack;
      cpu_ack  <= next_cpu_ack;
      if (bctl_req) begin
        bctl_rdata <= mem[bctl_addr];
        if (bctl_we) begin
          mem[bctl_addr] <= bctl_wdata;
        end
      end else if (cpu_go) begin
        cpu_rdata <= mem[cpu_word][8*cpu.addr[1:0] +: 8];
        if (cpu.we) begin
          mem[cpu_word][8*cpu.addr[1:0] +: 8] <= cpu.wdata;
        end
      end
    end
  end

  // checks, sampled only on enabled edges
  default clocking cb @(posedge clock iff ce); endclocking
  default disable iff (!nrst);

  sequence s_eof;
    rx_valid && rx_eof;
  endsequence
  sequence s_split_change;
    reg_wr && reg_addr == ADDR_SPLIT_SIZE && reg_wdata[4:0] != buffer_split_size;
  endsequence

  property p_perfect;
    s_eof ##0 (mode == 5'b00000 && !group) |=> rx_status.filter_fail != $past(da_match);
  endproperty
  a_perfect: assert property (p_perfect) else $error("perfect compare wrong");

  property p_inverse;
    s_eof ##0 (mode == 5'b00100 && !group) |=> rx_status.filter_fail == $past(da_match);
  endproperty
  a_inverse: assert property (p_inverse) else $error("inverse compare wrong");

  property p_group_fail;
    s_eof ##0 (mode == 5'b00000 && group && !bcast) |=> rx_status.filter_fail;
  endproperty
  a_group_fail: assert property (p_group_fail) else $error("group passed");

  property p_bcast;
    s_eof ##0 (mode == 5'b00000 && bcast && !mac_control[MC_BCAST_REJECT])
      |=> !rx_status.filter_fail && rx_status.broadcast && rx_status.multicast;
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast rejected");

  property p_promisc;
    s_eof ##0 (mode[3] && !mode[2]) |=> !rx_status.filter_fail;
  endproperty
  a_promisc: assert property (p_promisc) else $error("pass-all failed");

  property p_hash;
    s_eof ##0 (mode == 5'b00011) |=> rx_status.filter_fail != $past(hash_hit);
  endproperty
  a_hash: assert property (p_hash) else $error("hash result wrong");

  property p_single_len;
    rx_status_valid && rx_status.single_tag && !rx_status.double_tag
      |-> rx_status.too_long == (rx_status.length > BASE_MAX_LEN + SINGLE_EXTRA);
  endproperty
  a_single_len: assert property (p_single_len) else $error("tag limit wrong");

  property p_flush;
    s_split_change |=> rx_flush;
  endproperty
  a_flush: assert property (p_flush) else $error("flush missing");

  property p_flush_only;
    !(reg_wr && reg_addr == ADDR_SPLIT_SIZE && reg_wdata[4:0] != buffer_split_size) |=> !rx_flush;
  endproperty
  a_flush_only: assert property (p_flush_only) else $error("spurious flush");

  property p_bctl_served;
    bctl_req |=> bctl_ack && !cpu_ack;
  endproperty
  a_bctl_served: assert property (p_bctl_served) else $error("unit access lost");

  property p_cpu_served;
    cpu_req && cpu_hit && !cpu_ack && !bctl_req |=> cpu_ack;
  endproperty
  a_cpu_served: assert property (p_cpu_served) else $error("cpu access lost");

endmodule

// ### inc/eaf_pkg.sv
// eaf_pkg: register map, field positions, limits and carriers of the receive filter
package eaf_pkg;
  // register offsets on the plain register port
  localparam logic [7:0] ADDR_MAC_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STA_HIGH    = 8'h04;
  localparam logic [7:0] ADDR_STA_LOW     = 8'h08;
  localparam logic [7:0] ADDR_HASH_HIGH   = 8'h0c;
  localparam logic [7:0] ADDR_HASH_LOW    = 8'h10;
  localparam logic [7:0] ADDR_SINGLE_TAG  = 8'h20;
  localparam logic [7:0] ADDR_DOUBLE_TAG  = 8'h24;
  localparam logic [7:0] ADDR_LAST_STATUS = 8'h28;
  localparam logic [7:0] ADDR_MEM_WINDOW  = 8'hc6;
  localparam logic [7:0] ADDR_SPLIT_SIZE  = 8'he5;
  // mac_control field positions
  localparam int MC_BCAST_REJECT = 11;
  localparam int MC_HASH_GROUP   = 13;
  localparam int MC_HASH_SINGLE  = 15;
  localparam int MC_INVERSE      = 17;
  localparam int MC_ACCEPT_ALL   = 18;
  localparam int MC_PASS_GROUP   = 19;
  localparam logic [31:0] MAC_CONTROL_RST = 32'h0004_0000;
  // memory window and split fields
  localparam int WIN_LO = 6;
  localparam logic [1:0]  WIN_RST    = 2'h0;
  localparam logic [4:0]  SPLIT_RST  = 5'h00;
  localparam logic [23:0] WIN_BASE_0 = 24'h00e000;
  localparam logic [23:0] WIN_BASE_1 = 24'h000000;
  localparam logic [23:0] WIN_BASE_2 = 24'hffe000;
  // packet memory shape
  localparam int PAGES      = 32;
  localparam int PAGE_WORDS = 64;
  localparam int SRAM_WORDS = PAGES * PAGE_WORDS;
  localparam int WA_W       = 11;
  // frame layout and length limits
  localparam logic [13:0] DA_BYTES     = 14'd6;
  localparam logic [13:0] TAG_HI_IDX   = 14'd12;
  localparam logic [13:0] TAG_LO_IDX   = 14'd13;
  localparam logic [13:0] BASE_MAX_LEN = 14'd1518;
  localparam logic [13:0] SINGLE_EXTRA = 14'd4;
  localparam logic [13:0] DOUBLE_EXTRA = 14'd20;
  localparam logic [31:0] CRC_POLY     = 32'h04c11db7;
  localparam logic [31:0] CRC_PRESET   = 32'hffffffff;
  // last-status word bit positions
  localparam int ST_FAIL = 29;
  localparam int ST_BC = 28;
  localparam int ST_MC = 27;
  localparam int ST_V2 = 23;
  localparam int ST_V1 = 22;
  localparam int ST_LG = 16;
  // per-frame filter result
  typedef struct packed {
    logic        filter_fail;
    logic        broadcast;
    logic        multicast;
    logic        double_tag;
    logic        single_tag;
    logic        too_long;
    logic [13:0] length;
  } eaf_rx_status_t;
  // cpu byte access
  typedef struct packed {
    logic        we;
    logic [23:0] addr;
    logic [7:0]  wdata;
  } eaf_cpu_req_t;
endpackage

// ### test/eaf_phy_model.sv
// eaf_phy_model: receive-side stand-in that streams frame bytes into the filter
`timescale 1ns/1ns
module eaf_phy_model (
  input  wire logic       clock,
  output logic            rx_valid,
  output logic            rx_sof,
  output logic            rx_eof,
  output logic [7:0]      rx_byte
);
  // idle line at time zero
  initial begin
    rx_valid = 1'b0;
    rx_sof = 1'b0;
    rx_eof = 1'b0;
    rx_byte = 8'h00;
  end
  // one frame: destination, zero source, tag at bytes 12/13, counter filler; slow adds gaps
  task automatic send(input logic [47:0] da, input logic [15:0] tag, input int len,
                      input bit slow);
    logic [7:0] b;
    for (int i = 0; i < len; i++) begin
      b = (i < 6) ? da[47 - 8*i -: 8] : (i == 12) ? tag[15:8] : (i == 13) ? tag[7:0]
        : (i < 12) ? 8'h00 : i[7:0];
      @(posedge clock);
      rx_valid <= 1'b1;
      rx_sof <= (i == 0);
      rx_eof <= (i == len - 1);
      rx_byte <= b;
      if (slow && i != len - 1) begin
        @(posedge clock);
        rx_valid <= 1'b0;
        rx_byte <= ~b; // released data never shows the old byte
      end
    end
    @(posedge clock);
    rx_valid <= 1'b0;
    rx_sof <= 1'b0;
    rx_eof <= 1'b0;
    rx_byte <= ~b;
  endtask
endmodule

// ### test/eaf_filter_tb.sv
// eaf_filter_tb: self-checking bench for address filter, tags, split and packet memory
`timescale 1ns/1ns
module eaf_filter_tb;
  import eaf_pkg::*;
  localparam logic [31:0] HG = 32'h1 << MC_HASH_GROUP;
  localparam logic [31:0] HS = 32'h1 << MC_HASH_SINGLE;
  localparam logic [31:0] PG = 32'h1 << MC_PASS_GROUP;
  localparam logic [47:0] STA = 48'h0a1b_2c3d_4e5f;
  logic            clock, nrst, ce, reg_wr, reg_rd, bctl_req, bctl_we, cpu_req, cpu_ack, bctl_ack;
  logic            rx_valid, rx_sof, rx_eof, rx_status_valid, rx_flush;
  logic [7:0]      reg_addr, rx_byte, cpu_rdata, q8;
  logic [31:0]     reg_wdata, reg_rdata, bctl_wdata, bctl_rdata, q32;
  logic [4:0]      rx_page_count;
  logic [WA_W-1:0] bctl_addr;
  eaf_rx_status_t  rx_status;
  eaf_cpu_req_t    cpu;
  int              n_errors, check_count, cyc;

  eaf_filter eaf_filter_i (.clock(clock), .nrst(nrst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_byte(rx_byte),
    .rx_status(rx_status), .rx_status_valid(rx_status_valid), .rx_flush(rx_flush),
    .rx_page_count(rx_page_count), .bctl_req(bctl_req), .bctl_we(bctl_we),
    .bctl_addr(bctl_addr), .bctl_wdata(bctl_wdata), .bctl_rdata(bctl_rdata),
    .bctl_ack(bctl_ack), .cpu_req(cpu_req),
    .cpu(cpu), .cpu_rdata(cpu_rdata), .cpu_ack(cpu_ack));
  eaf_phy_model phy_i (.clock(clock), .rx_valid(rx_valid), .rx_sof(rx_sof),
    .rx_eof(rx_eof), .rx_byte(rx_byte));

  // clock and hang guard
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      end_sim();
    end
  end

  // shared compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask
  // register bus cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  // one frame, then status {fail,bcast,mcast,double,single,long} and length
  task automatic frame(input logic [47:0] da, input logic [15:0] tag, input int len,
                       input logic [5:0] exp);
    phy_i.send(da, tag, len, len[0]);
    #1;
    for (int k = 0; k < 3 && rx_status_valid !== 1'b1; k++) begin
      @(posedge clock);
      #1;
    end
    chk(rx_status_valid, 1'b1);
    chk({rx_status.filter_fail, rx_status.broadcast, rx_status.multicast,
         rx_status.double_tag, rx_status.single_tag, rx_status.too_long}, exp);
    chk(rx_status.length, len[13:0]);
  endtask
  // expected hash index: all-ones preset, bit0 of each byte first
  function automatic logic [5:0] hidx(input logic [47:0] da);
    logic [31:0] c;
    logic        fb;
    c = CRC_PRESET;
    for (int i = 0; i < 48; i++) begin
      fb = c[31] ^ da[40 - 8*(i/8) + (i%8)];
      c = {c[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h0);
    end
    return c[31:26];
  endfunction
  // memory port cycles
  task automatic cpu_acc(input logic we, input logic [23:0] a, input logic [7:0] d,
                         output logic [7:0] q);
    @(posedge clock);
    cpu_req <= 1'b1;
    cpu <= '{we, a, d};
    for (int k = 0; k < 8; k++) begin
      @(posedge clock);
      if (cpu_ack === 1'b1) break;
    end
    q = cpu_rdata;
    chk(cpu_ack, 1'b1);
    cpu_req <= 1'b0;
    cpu <= '{1'b0, ~a, ~d};
  endtask
  task automatic bctl_acc(input logic we, input logic [10:0] a, input logic [31:0] d,
                          output logic [31:0] q);
    @(posedge clock);
    bctl_req <= 1'b1;
    bctl_we <= we;
    bctl_addr <= a;
    bctl_wdata <= d;
    @(posedge clock);
    bctl_req <= 1'b0;
    #1;
    chk(bctl_ack, 1'b1);
    q = bctl_rdata;
  endtask

  // scenarios
  task automatic t_reset();
    rd(ADDR_MAC_CONTROL, MAC_CONTROL_RST);
    chk(rx_page_count, 32'h0);
    rd(8'h30, 32'h0);
    frame(48'h0200_0000_0009, 16'h0800, 64, 6'b000000);
  endtask
  task automatic t_perfect();
    wr(ADDR_STA_HIGH, {16'h0, STA[47:32]});
    wr(ADDR_STA_LOW, STA[31:0]);
    wr(ADDR_MAC_CONTROL, 32'h0);
    frame(STA, 16'h0800, 64, 6'b000000);
    frame(STA ^ 48'h1, 16'h0800, 65, 6'b100000);
    frame(STA | 48'h0100_0000_0000, 16'h0800, 64, 6'b101000);
    frame(48'hffff_ffff_ffff, 16'h0800, 64, 6'b011000);
    wr(ADDR_MAC_CONTROL, 32'h1 << MC_BCAST_REJECT);
    frame(48'hffff_ffff_ffff, 16'h0800, 64, 6'b111000);
  endtask
  task automatic t_inverse();
    wr(ADDR_MAC_CONTROL, 32'h1 << MC_INVERSE);
    frame(STA, 16'h0800, 64, 6'b100000);
    frame(STA ^ 48'h10, 16'h0800, 64, 6'b000000);
    frame(STA | 48'h0100_0000_0000, 16'h0800, 64, 6'b101000);
    wr(ADDR_MAC_CONTROL, PG);
    frame(48'h0300_0000_0001, 16'h0800, 64, 6'b001000);
    frame(STA ^ 48'h2, 16'h0800, 64, 6'b100000);
  endtask
  task automatic t_hash();
    logic [5:0] a;
    logic [5:0] b;
    logic [5:0] u;
    a = hidx(48'h0100_5e00_0001);
    b = hidx(48'h0100_5e00_00fb);
    u = hidx(48'h0200_0000_0077);
    wr(ADDR_HASH_HIGH, a[5] ? 32'h1 << a[4:0] : 32'h0);
    wr(ADDR_HASH_LOW, a[5] ? 32'h0 : 32'h1 << a[4:0]);
    wr(ADDR_MAC_CONTROL, HG | HS);
    frame(48'h0100_5e00_0001, 16'h0800, 64, 6'b001000);
    frame(48'h0100_5e00_00fb, 16'h0800, 64, {b != a, 5'b01000});
    frame(48'h0200_0000_0077, 16'h0800, 64, {u != a, 5'b00000});
    wr(ADDR_MAC_CONTROL, HG);
    frame(48'h0100_5e00_0001, 16'h0800, 64, 6'b001000);
    frame(STA, 16'h0800, 64, 6'b000000);
    wr(ADDR_MAC_CONTROL, PG | HG | HS);
    frame(48'h0100_5e00_00fb, 16'h0800, 64, 6'b001000);
  endtask
  task automatic t_vlan();
    wr(ADDR_SINGLE_TAG, 32'h8100);
    wr(ADDR_DOUBLE_TAG, 32'h9100);
    wr(ADDR_MAC_CONTROL, MAC_CONTROL_RST);
    frame(STA, 16'h8100, 1522, 6'b000010);
    frame(STA, 16'h8100, 1523, 6'b000011);
    frame(STA, 16'h9100, 1538, 6'b000100);
    frame(STA, 16'h9100, 1539, 6'b000101);
    frame(STA, 16'h0800, 1519, 6'b000001);
    rd(ADDR_LAST_STATUS, (32'h1 << ST_LG) | 32'd1519);
  endtask
  task automatic t_split();
    wr(ADDR_SPLIT_SIZE, 32'h10);
    chk({rx_flush, rx_page_count}, {1'b1, 5'h10});
    wr(ADDR_SPLIT_SIZE, 32'h3f);
    chk({rx_flush, rx_page_count}, {1'b1, 5'h1f});
    wr(ADDR_SPLIT_SIZE, 32'h1f);
    chk({rx_flush, rx_page_count}, {1'b0, 5'h1f});
    @(posedge clock);
    ce <= 1'b0;
    wr(ADDR_SPLIT_SIZE, 32'h05);
    chk({rx_flush, rx_page_count}, {1'b0, 5'h1f});
    @(posedge clock);
    ce <= 1'b1;
    rd(ADDR_SPLIT_SIZE, 32'h1f);
  endtask
  task automatic t_mem();
    bctl_acc(1'b1, 11'd2047, 32'hcafe_f00d, q32);
    cpu_acc(1'b0, 24'h00ffff, 8'h00, q8);
    chk(q8, 8'hca);
    wr(ADDR_MEM_WINDOW, 32'h40);
    cpu_acc(1'b0, 24'h001ffc, 8'h00, q8);
    chk(q8, 8'h0d);
    wr(ADDR_MEM_WINDOW, 32'h80);
    cpu_acc(1'b0, 24'hfffffd, 8'h00, q8);
    chk(q8, 8'hf0);
    wr(ADDR_MEM_WINDOW, 32'h00);
    fork
      cpu_acc(1'b1, 24'h00e001, 8'h5a, q8);
      bctl_acc(1'b0, 11'd2047, 32'h0, q32);
    join
    chk(q32, 32'hcafe_f00d);
    cpu_acc(1'b0, 24'h00e001, 8'h00, q8);
    chk(q8, 8'h5a);
  endtask

  // verdict and end of run
  task automatic end_sim();
    $display("errors=%0d checks=%0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // reset, then scenarios in turn
  initial begin
    {nrst, reg_wr, reg_rd, bctl_req, bctl_we, cpu_req} = 6'h0;
    ce = 1'b1;
    {reg_addr, reg_wdata, bctl_addr, bctl_wdata} = '0;
    cpu = '0;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    t_reset();
    t_perfect();
    t_inverse();
    t_hash();
    t_vlan();
    t_split();
    t_mem();
    end_sim();
  end
endmodule
